// ===== logic/swc_pkg.sv
// Operation
// - Writing one to bit 1 enters Power-Down; external interrupt or reset clears it.
// - Writing one to bit 0 enters Idle; interrupt or reset clears it.
// - Suspend needs key write then request write; otherwise hardware clears them.
// - Both request bits set enters Power-Down only; exit clears both.
// - Bits 3 and 2 are plain software flags without hardware effect.
// - Bit 6 selects the serial control upper field function.
// - Bit 7 doubles the serial baud rate when set.
// - After power-on, power warm-up runs first, then oscillator warm-up.
// - Power warm-up on 2MHz RC: 11ms, 1000 clocks after watchdog, 64 on wakeup.
// - Oscillator warm-up follows all resets and Power-Down wakeups except watchdog or overload reset outside Power-Down.
// - Crystal warm-up is 2^17, 2^14, 2^11 or 2^8 periods by select code.
// - Internal RC oscillator ignores select; warm-up is always 2^7 periods.
// - Source code 1110 selects crystal; every other code selects internal RC.
// - Range option 0 selects 2M-16M, 1 selects 400K-2M.
// - Reset pin option 0 makes the shared pin a reset input, 1 general I/O.
// - Low-voltage reset enable option, and level option picks level 1 or 2.
// - Watchdog enable option 0 disables, 1 enables the watchdog.
// - Watchdog-in-sleep option 1 keeps the watchdog running in Power-Down.
// - Overload action option 0 raises reset, 1 raises interrupt.
// - Only external interrupt or reset wakes Power-Down; clocks resume after warm-up.
`default_nettype none
package swc_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] PWRC_ADDR = 8'h87;
  localparam logic [7:0] KEY_ADDR = 8'h8e;
  localparam logic [7:0] PWRC_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam logic [7:0] KEY_VALUE = 8'h55;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  localparam int BIT_IDLE = 0;
  localparam int BIT_DOWN_REQ = 1;
  localparam int BIT_FLAG0 = 2;
  localparam int BIT_FLAG1 = 3;
  localparam int BIT_STAT_SEL = 6;
  localparam int BIT_BAUD = 7;

  // ==========================================
  // Code options
  localparam logic [3:0] OSC_XTAL_CODE = 4'he;
  localparam logic [1:0] WMT_LONGEST = 2'h0;
  localparam logic [1:0] WMT_LONGER = 2'h1;
  localparam logic [1:0] WMT_SHORTER = 2'h2;
  localparam logic [1:0] WMT_SHORTEST = 2'h3;
  localparam int EXP_LONGEST = 17;
  localparam int EXP_LONGER = 14;
  localparam int EXP_SHORTER = 11;
  localparam int EXP_SHORTEST = 8;
  localparam int EXP_RC = 7;

  // ==========================================
  // Power warm-up timing in 2MHz RC ticks
  localparam int PWR_LONG_MS = 11;
  localparam int RC_KHZ = 2000;
  localparam int PWR_LONG_TICKS = PWR_LONG_MS * RC_KHZ;
  localparam int PWR_DOG_TICKS = 1000;
  localparam int PWR_WAKE_TICKS = 64;
  localparam int PWR_W = 15;
  localparam int OSC_W = 18;

  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {
    SWC_RUN,
    SWC_IDLE,
    SWC_PDOWN,
    SWC_PWR_WARM,
    SWC_OSC_WARM
  } swc_state_t;
endpackage
`default_nettype wire

// ===== logic/swc_top.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module swc_top #(
  parameter int PWR_LONG = swc_pkg::PWR_LONG_TICKS,
  parameter int PWR_DOG = swc_pkg::PWR_DOG_TICKS,
  parameter int PWR_WAKE = swc_pkg::PWR_WAKE_TICKS,
  parameter int OSC_EXP_CUT = 0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic rc_tick_in,
  input wire logic osc_tick_in,
  input wire logic shared_reset_pin_n_in,
  input wire logic low_voltage_reset_in,
  input wire logic watchdog_timer_reset_in,
  input wire logic overload_event_in,
  input wire logic ext_wake_in,
  input wire logic irq_in,
  input wire logic [3:0] osc_source_select_in,
  input wire logic [1:0] osc_warmup_select_in,
  input wire logic osc_range_select_in,
  input wire logic reset_pin_select_in,
  input wire logic lowvolt_reset_enable_in,
  input wire logic lowvolt_level_select_in,
  input wire logic watchdog_enable_opt_in,
  input wire logic watchdog_in_sleep_opt_in,
  input wire logic overload_action_select_in,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic osc_enable_out,
  output logic cpu_reset_out,
  output logic baud_double_out,
  output logic serial_status_select_out,
  output logic xtal_mode_out,
  output logic osc_range_low_out,
  output logic reset_pin_is_io_out,
  output logic lowvolt_enable_out,
  output logic lowvolt_level_out,
  output logic watchdog_run_out,
  output logic overload_reset_out,
  output logic overload_irq_out
);
  // ==========================================
  // Register file
  swc_pkg::swc_state_t state_q, state_d;
  logic [1:0] req_q;
  logic [3:0] ctrl_q;
  logic [7:0] key_q;
  logic key_fresh_q;
  logic [7:0] rdata_q;
  logic [swc_pkg::PWR_W-1:0] pwr_cnt_q, pwr_len;
  logic [swc_pkg::OSC_W-1:0] osc_cnt_q, osc_len;
  logic osc_need_q, osc_need_d, hold_rst_q, hold_rst_d;
  logic ctrl_wr, key_wr, enter_ok, leave_run;
  logic long_evt, dog_evt, rst_evt, wake_evt, pwr_load;
  logic xtal;
  int osc_exp;

  assign ctrl_wr = wr_in && (addr_in == swc_pkg::PWRC_ADDR);
  assign key_wr = wr_in && (addr_in == swc_pkg::KEY_ADDR);

  // Reset sources gated by their options
  assign long_evt = (!reset_pin_select_in && !shared_reset_pin_n_in)
    || (lowvolt_reset_enable_in && low_voltage_reset_in);
  assign dog_evt = (watchdog_run_out && watchdog_timer_reset_in)
    || (!overload_action_select_in && overload_event_in);
  assign rst_evt = long_evt || dog_evt;
  assign wake_evt = (state_q == swc_pkg::SWC_PDOWN) && ext_wake_in;

  // Key then request in consecutive cycles
  assign enter_ok = ctrl_wr && key_fresh_q && (key_q == swc_pkg::KEY_VALUE)
    && (|wdata_in[swc_pkg::BIT_DOWN_REQ:swc_pkg::BIT_IDLE])
    && (state_q == swc_pkg::SWC_RUN) && !rst_evt;

  // Oscillator warm-up length
  assign xtal = (osc_source_select_in == swc_pkg::OSC_XTAL_CODE);
  always_comb begin
    if (!xtal) begin
      osc_exp = swc_pkg::EXP_RC;
    end else begin
      unique case (osc_warmup_select_in)
        swc_pkg::WMT_LONGEST: osc_exp = swc_pkg::EXP_LONGEST;
        swc_pkg::WMT_LONGER: osc_exp = swc_pkg::EXP_LONGER;
        swc_pkg::WMT_SHORTER: osc_exp = swc_pkg::EXP_SHORTER;
        swc_pkg::WMT_SHORTEST: osc_exp = swc_pkg::EXP_SHORTEST;
      endcase
    end
    osc_len = swc_pkg::OSC_W'(1) << (osc_exp - OSC_EXP_CUT);
  end

  // ==========================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    osc_need_d = osc_need_q;
    hold_rst_d = hold_rst_q;
    pwr_load = 1'b0;
    pwr_len = swc_pkg::PWR_W'(PWR_LONG);
    if (long_evt) begin
      state_d = swc_pkg::SWC_PWR_WARM;
      pwr_load = 1'b1;
      osc_need_d = 1'b1;
      hold_rst_d = 1'b1;
    end else if (dog_evt) begin
      state_d = swc_pkg::SWC_PWR_WARM;
      pwr_load = 1'b1;
      pwr_len = swc_pkg::PWR_W'(PWR_DOG);
      osc_need_d = (state_q == swc_pkg::SWC_PDOWN);
      hold_rst_d = 1'b1;
    end else begin
      unique case (state_q)
        swc_pkg::SWC_RUN: begin
          if (enter_ok && wdata_in[swc_pkg::BIT_DOWN_REQ]) begin
            state_d = swc_pkg::SWC_PDOWN;
          end else if (enter_ok) begin
            state_d = swc_pkg::SWC_IDLE;
          end
        end
        swc_pkg::SWC_IDLE: begin
          if (irq_in) begin
            state_d = swc_pkg::SWC_RUN;
          end
        end
        swc_pkg::SWC_PDOWN: begin
          if (wake_evt) begin
            state_d = swc_pkg::SWC_PWR_WARM;
            pwr_load = 1'b1;
            pwr_len = swc_pkg::PWR_W'(PWR_WAKE);
            osc_need_d = 1'b1;
            hold_rst_d = 1'b0;
          end
        end
        swc_pkg::SWC_PWR_WARM: begin
          if (rc_tick_in && pwr_cnt_q <= swc_pkg::PWR_W'(1)) begin
            state_d = osc_need_q ? swc_pkg::SWC_OSC_WARM : swc_pkg::SWC_RUN;
          end
        end
        swc_pkg::SWC_OSC_WARM: begin
          if (osc_tick_in && osc_cnt_q <= swc_pkg::OSC_W'(1)) begin
            state_d = swc_pkg::SWC_RUN;
          end
        end
      endcase
    end
  end
  assign leave_run = (state_d == swc_pkg::SWC_RUN) && (state_q != swc_pkg::SWC_RUN);

  // State and reset hold
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q <= swc_pkg::SWC_PWR_WARM;
      osc_need_q <= 1'b1;
      hold_rst_q <= 1'b1;
    end else begin
      state_q <= state_d;
      osc_need_q <= osc_need_d;
      hold_rst_q <= leave_run ? 1'b0 : hold_rst_d;
    end
  end

  // Power warm-up counter on RC ticks
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pwr_cnt_q <= swc_pkg::PWR_W'(PWR_LONG);
    end else if (pwr_load) begin
      pwr_cnt_q <= pwr_len;
    end else if (state_q == swc_pkg::SWC_PWR_WARM && rc_tick_in) begin
      pwr_cnt_q <= pwr_cnt_q - swc_pkg::PWR_W'(1);
    end
  end

  // Oscillator warm-up counter on oscillator periods
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      osc_cnt_q <= '0;
    end else if (state_d == swc_pkg::SWC_OSC_WARM && state_q != swc_pkg::SWC_OSC_WARM) begin
      osc_cnt_q <= osc_len;
    end else if (state_q == swc_pkg::SWC_OSC_WARM && osc_tick_in) begin
      osc_cnt_q <= osc_cnt_q - swc_pkg::OSC_W'(1);
    end
  end

  // ==========================================
  // Request bits
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || rst_evt || leave_run) begin
      req_q <= swc_pkg::PWRC_RESET[1:0];
    end else if (ctrl_wr && state_q == swc_pkg::SWC_RUN) begin
      req_q <= wdata_in[swc_pkg::BIT_DOWN_REQ:swc_pkg::BIT_IDLE];
    end else if (state_q == swc_pkg::SWC_RUN) begin
      req_q <= swc_pkg::PWRC_RESET[1:0];
    end
  end

  // Plain control bits: flags, status select, baud double
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || rst_evt) begin
      ctrl_q <= swc_pkg::PWRC_RESET[3:0];
    end else if (ctrl_wr) begin
      ctrl_q <= {wdata_in[swc_pkg::BIT_BAUD], wdata_in[swc_pkg::BIT_STAT_SEL],
        wdata_in[swc_pkg::BIT_FLAG1], wdata_in[swc_pkg::BIT_FLAG0]};
    end
  end

  // Suspend key
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || rst_evt || leave_run) begin
      key_q <= swc_pkg::KEY_RESET;
      key_fresh_q <= 1'b0;
    end else begin
      key_fresh_q <= key_wr;
      if (key_wr) begin
        key_q <= wdata_in;
      end else if (key_fresh_q && !ctrl_wr && state_q == swc_pkg::SWC_RUN) begin
        key_q <= swc_pkg::KEY_RESET;
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !rd_in) begin
      rdata_q <= swc_pkg::RDATA_NONE;
    end else if (addr_in == swc_pkg::PWRC_ADDR) begin
      rdata_q <= {ctrl_q[3:2], 2'h0, ctrl_q[1:0], req_q};
    end else if (addr_in == swc_pkg::KEY_ADDR) begin
      rdata_q <= key_q;
    end else begin
      rdata_q <= swc_pkg::RDATA_NONE;
    end
  end
  assign rdata_out = rdata_q;

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cpu_clk_en_out <= 1'b0;
      periph_clk_en_out <= 1'b0;
      osc_enable_out <= 1'b1;
      cpu_reset_out <= 1'b1;
    end else begin
      cpu_clk_en_out <= (state_d == swc_pkg::SWC_RUN);
      periph_clk_en_out <= (state_d == swc_pkg::SWC_RUN) || (state_d == swc_pkg::SWC_IDLE);
      osc_enable_out <= (state_d != swc_pkg::SWC_PDOWN);
      cpu_reset_out <= (state_d != swc_pkg::SWC_RUN) && hold_rst_d;
    end
  end

  // Option and control outputs
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      baud_double_out <= 1'b0;
      serial_status_select_out <= 1'b0;
      xtal_mode_out <= 1'b0;
      osc_range_low_out <= 1'b0;
      reset_pin_is_io_out <= 1'b0;
      lowvolt_enable_out <= 1'b0;
      lowvolt_level_out <= 1'b0;
      watchdog_run_out <= 1'b0;
      overload_reset_out <= 1'b0;
      overload_irq_out <= 1'b0;
    end else begin
      baud_double_out <= ctrl_q[3];
      serial_status_select_out <= ctrl_q[2];
      xtal_mode_out <= xtal;
      osc_range_low_out <= osc_range_select_in;
      reset_pin_is_io_out <= reset_pin_select_in;
      lowvolt_enable_out <= lowvolt_reset_enable_in;
      lowvolt_level_out <= lowvolt_level_select_in;
      watchdog_run_out <= watchdog_enable_opt_in
        && (state_d != swc_pkg::SWC_PDOWN || watchdog_in_sleep_opt_in);
      overload_reset_out <= overload_event_in && !overload_action_select_in;
      overload_irq_out <= overload_event_in && overload_action_select_in;
    end
  end

  // ==========================================
  // Checks
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_key_then_req;
    key_wr && wdata_in == swc_pkg::KEY_VALUE && state_q == swc_pkg::SWC_RUN && !rst_evt
      ##1 ctrl_wr && |wdata_in[1:0] && !rst_evt;
  endsequence

  a_pd_priority: assert property (s_key_then_req ##0 wdata_in[1] |=>
    state_q == swc_pkg::SWC_PDOWN) else $error("power-down not entered");
  a_idle_entry: assert property (s_key_then_req ##0 !wdata_in[1] |=>
    state_q == swc_pkg::SWC_IDLE) else $error("idle not entered");
  a_req_reject: assert property (ctrl_wr && !enter_ok && !rst_evt
    && state_q == swc_pkg::SWC_RUN |=> state_q == swc_pkg::SWC_RUN ##1 req_q == 2'h0)
    else $error("request bits not cleared");
  a_key_clear: assert property (key_fresh_q && !ctrl_wr && !rst_evt
    && state_q == swc_pkg::SWC_RUN |=> key_q == swc_pkg::KEY_RESET)
    else $error("key not cleared");
  a_wake_warm: assert property (wake_evt && !rst_evt |=>
    state_q == swc_pkg::SWC_PWR_WARM && pwr_cnt_q == swc_pkg::PWR_W'(PWR_WAKE))
    else $error("wake warm-up wrong");
  a_dog_skip: assert property (dog_evt && !long_evt && state_q == swc_pkg::SWC_RUN |=>
    !osc_need_q && pwr_cnt_q == swc_pkg::PWR_W'(PWR_DOG)) else $error("watchdog warm-up wrong");
  a_long_warm: assert property (long_evt |=>
    osc_need_q && pwr_cnt_q == swc_pkg::PWR_W'(PWR_LONG)) else $error("long warm-up wrong");
  a_osc_len: assert property ($rose(state_q == swc_pkg::SWC_OSC_WARM) |->
    osc_cnt_q == $past(osc_len)) else $error("osc warm-up length wrong");
  a_clk_gated: assert property (state_q inside {swc_pkg::SWC_PWR_WARM,
    swc_pkg::SWC_OSC_WARM, swc_pkg::SWC_PDOWN} |-> !cpu_clk_en_out)
    else $error("cpu clock during warm-up");
  a_baud_bit: assert property (ctrl_wr && !rst_evt |=> ##1
    baud_double_out == $past(wdata_in[7], 2)) else $error("baud double not stored");
endmodule
`default_nettype wire

// ===== tb/tb_suspend_and_warmup_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_suspend_and_warmup_control;
  localparam int P_LONG = 20;
  localparam int P_DOG = 10;
  localparam int P_WAKE = 4;
  localparam int CUT = 4;
  logic clk_in, reset_n_in, wr_in, rd_in, rc_tick_in, osc_tick_in;
  logic [7:0] addr_in, wdata_in, rdata_out;
  logic shared_reset_pin_n_in, low_voltage_reset_in, watchdog_timer_reset_in;
  logic overload_event_in, ext_wake_in, irq_in, osc_range_select_in;
  logic [3:0] osc_source_select_in;
  logic [1:0] osc_warmup_select_in;
  logic reset_pin_select_in, lowvolt_reset_enable_in, lowvolt_level_select_in;
  logic watchdog_enable_opt_in, watchdog_in_sleep_opt_in, overload_action_select_in;
  logic cpu_clk_en_out, periph_clk_en_out, osc_enable_out, cpu_reset_out;
  logic baud_double_out, serial_status_select_out, xtal_mode_out, osc_range_low_out;
  logic reset_pin_is_io_out, lowvolt_enable_out, lowvolt_level_out, watchdog_run_out;
  logic overload_reset_out, overload_irq_out;
  logic [31:0] v;
  int num_errors = 0;
  int checks_done = 0;

  swc_top #(.PWR_LONG(P_LONG), .PWR_DOG(P_DOG), .PWR_WAKE(P_WAKE), .OSC_EXP_CUT(CUT)) dut_u (
    .clk_in, .reset_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rc_tick_in,
    .osc_tick_in, .shared_reset_pin_n_in, .low_voltage_reset_in, .watchdog_timer_reset_in,
    .overload_event_in, .ext_wake_in, .irq_in, .osc_source_select_in, .osc_warmup_select_in,
    .osc_range_select_in, .reset_pin_select_in, .lowvolt_reset_enable_in,
    .lowvolt_level_select_in, .watchdog_enable_opt_in, .watchdog_in_sleep_opt_in,
    .overload_action_select_in, .cpu_clk_en_out, .periph_clk_en_out, .osc_enable_out,
    .cpu_reset_out, .baud_double_out, .serial_status_select_out, .xtal_mode_out,
    .osc_range_low_out, .reset_pin_is_io_out, .lowvolt_enable_out, .lowvolt_level_out,
    .watchdog_run_out, .overload_reset_out, .overload_irq_out);

  // ==========================================
  // Clock and tick sources
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // RC tick every second cycle, oscillator tick every cycle
  always @(posedge clk_in) begin
    rc_tick_in <= ~rc_tick_in;
    osc_tick_in <= 1'b1;
  end

  // ==========================================
  // Helpers
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_in <= 1'b1;
    rd_in <= 1'b0;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
  endtask
  task automatic idle(input int n);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
    repeat (n) @(posedge clk_in);
  endtask
  // Read data is looked at in the one cycle it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, e);
    @(posedge clk_in);
  endtask
  task automatic suspend(input logic [7:0] req);
    wr(8'h8e, swc_pkg::KEY_VALUE);
    wr(8'h87, req);
    idle(1);
    #1;
  endtask
  // Expected cycles from event release to processor clock
  function automatic int warm(input int pwr, input logic [3:0] src, input logic [1:0] sel);
    int e;
    e = (src == 4'he) ? 17 - 3 * int'(sel) : 7;
    return 2 * pwr + (1 << (e - CUT));
  endfunction
  // Bounded wait for the processor clock, then window check
  task automatic measure(input int e, input logic rst);
    int n;
    n = 0;
    idle(1);
    #1;
    chk({7'h00, cpu_reset_out}, {7'h00, rst});
    while (cpu_clk_en_out !== 1'b1 && n < 20000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 20000) begin
      num_errors++;
      give_verdict();
    end
    chk({7'h00, n >= e - 3 && n <= e + 6}, 8'h01);
  endtask
  task automatic pulse_clk();
    @(posedge clk_in);
    watchdog_timer_reset_in <= 1'b0;
    overload_event_in <= 1'b0;
    shared_reset_pin_n_in <= 1'b1;
    low_voltage_reset_in <= 1'b0;
    ext_wake_in <= 1'b0;
    irq_in <= 1'b0;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    {reset_n_in, wr_in, rd_in, rc_tick_in, osc_tick_in, addr_in, wdata_in} = '0;
    {low_voltage_reset_in, watchdog_timer_reset_in, overload_event_in, ext_wake_in} = '0;
    {irq_in, osc_source_select_in, osc_warmup_select_in, osc_range_select_in} = '0;
    {reset_pin_select_in, lowvolt_reset_enable_in, lowvolt_level_select_in} = '0;
    {watchdog_enable_opt_in, watchdog_in_sleep_opt_in} = '0;
    overload_action_select_in = 1'b1;
    shared_reset_pin_n_in = 1'b1;
    v = $urandom(32'ha919_3d06);
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    measure(warm(P_LONG, 4'h0, 2'h0), 1'b1);
    rd(8'h87, 8'h00);
    rd(8'h8e, 8'h00);
    rd(8'h20, 8'h00);
    $display("test power_on finished");
    // Random option levels with overload pulses as interrupts
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      osc_source_select_in <= (i == 0) ? 4'he : v[3:0];
      {osc_range_select_in, reset_pin_select_in, lowvolt_reset_enable_in} <= v[6:4];
      {lowvolt_level_select_in, watchdog_enable_opt_in} <= v[8:7];
      overload_event_in <= 1'b1;
      pulse_clk();
      #1;
      chk({overload_irq_out, overload_reset_out}, 8'h02);
      @(posedge clk_in);
      #1;
      chk({2'b00, xtal_mode_out, osc_range_low_out, reset_pin_is_io_out, lowvolt_enable_out,
           lowvolt_level_out, watchdog_run_out},
          {2'b00, i == 0 || v[3:0] == 4'he, v[6], v[5], v[4], v[8], v[7]});
    end
    $display("test options finished");
    // Warm-up lengths after pin and low-voltage resets
    for (int i = 0; i < 5; i++) begin
      osc_source_select_in <= (i == 4) ? 4'h3 : 4'he;
      osc_warmup_select_in <= 2'(i);
      {lowvolt_reset_enable_in, reset_pin_select_in} <= 2'b10;
      @(posedge clk_in);
      if (i == 4) begin
        low_voltage_reset_in <= 1'b1;
      end else begin
        shared_reset_pin_n_in <= 1'b0;
      end
      pulse_clk();
      measure(warm(P_LONG, (i == 4) ? 4'h3 : 4'he, 2'(i)), 1'b1);
    end
    reset_pin_select_in <= 1'b1;
    shared_reset_pin_n_in <= 1'b0;
    idle(4);
    chk({7'h00, cpu_clk_en_out}, 8'h01);
    pulse_clk();
    $display("test warm_up finished");
    // Plain storage bits and serial controls
    for (int i = 0; i < 8; i++) begin
      v = $urandom & 32'h0000_00cc;
      wr(8'h87, v[7:0]);
      rd(8'h87, v[7:0]);
      chk({6'h00, baud_double_out, serial_status_select_out}, {6'h00, v[7:6]});
    end
    $display("test storage finished");
    // Requests without the key sequence are dropped
    wr(8'h87, 8'h02);
    idle(2);
    rd(8'h87, 8'h00);
    wr(8'h8e, swc_pkg::KEY_VALUE);
    wr(8'h20, 8'h00);
    wr(8'h87, 8'h01);
    idle(2);
    chk({6'h00, osc_enable_out, cpu_clk_en_out}, 8'h03);
    rd(8'h87, 8'h00);
    rd(8'h8e, 8'h00);
    $display("test refused finished");
    // Idle entry and interrupt exit
    suspend(8'h01);
    chk({6'h00, cpu_clk_en_out, periph_clk_en_out}, 8'h01);
    irq_in <= 1'b1;
    pulse_clk();
    idle(3);
    chk({7'h00, cpu_clk_en_out}, 8'h01);
    rd(8'h87, 8'h00);
    rd(8'h8e, 8'h00);
    $display("test idle finished");
    // Both requests: Power-Down only, woken by external interrupt
    osc_source_select_in <= 4'he;
    osc_warmup_select_in <= 2'h3;
    watchdog_enable_opt_in <= 1'b1;
    suspend(8'h03);
    chk({5'h00, osc_enable_out, periph_clk_en_out, watchdog_run_out}, 8'h00);
    irq_in <= 1'b1;
    idle(6);
    chk({7'h00, osc_enable_out}, 8'h00);
    irq_in <= 1'b0;
    ext_wake_in <= 1'b1;
    pulse_clk();
    measure(warm(P_WAKE, 4'he, 2'h3), 1'b0);
    rd(8'h87, 8'h00);
    idle(3);
    chk({7'h00, cpu_clk_en_out}, 8'h01);
    $display("test power_down finished");
    // Watchdog outside and inside Power-Down, then overload reset
    osc_warmup_select_in <= 2'h0;
    watchdog_in_sleep_opt_in <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (k == 1) begin
        suspend(8'h02);
        chk({7'h00, watchdog_run_out}, 8'h01);
      end
      if (k == 2) begin
        overload_action_select_in <= 1'b0;
        @(posedge clk_in);
        overload_event_in <= 1'b1;
      end else begin
        watchdog_timer_reset_in <= 1'b1;
      end
      pulse_clk();
      #1;
      if (k == 2) chk({7'h00, overload_reset_out}, 8'h01);
      measure(2 * P_DOG + ((k == 1) ? (1 << (17 - CUT)) : 0), 1'b1);
      rd(8'h87, 8'h00);
    end
    overload_action_select_in <= 1'b1;
    $display("test watchdog finished");
    give_verdict();
  end
endmodule
`default_nettype wire
